// >>> core/trig_line_regs.vh
// Constants for the trigger line controller: line positions, reset values and timing.
// Function
// - The block drives seven trigger output lines and senses eight trigger input lines.
// - Inputs one to six and outputs one to six pair up, one pair per shared bus line.
// - The seventh output is the meter-complete signal to outside equipment.
// - The seventh input is the external trigger coming from outside equipment.
// - The eighth input carries the bus controller's group execute trigger.
// - A bus trigger is made by switching on that line's pull-down; idle lines rest high.
// - With an input selected, pulsing its paired output on and off registers a trigger.
// - Nothing inside links meter-complete to the external trigger input.
// - Any single input can be the trigger source while the other lines are toggled.
`ifndef TRIG_LINE_REGS_VH
`define TRIG_LINE_REGS_VH

// ==========================================================
// Line counts and positions
`define TRIG_OUT_COUNT 7
`define TRIG_IN_COUNT 8
`define TRIG_BUS_LINES 6
`define TRIG_METER_DONE_BIT 6
`define TRIG_EXT_IN_BIT 6
`define TRIG_EXEC_IN_BIT 7
`define TRIG_SEL_BUS_LIMIT 3'h6
`define TRIG_SEL_LAST_OUT 3'h6

// ==========================================================
// Reset values and the event count limit
`define TRIG_IN_RST 8'h7F
`define TRIG_OUT_RST 7'h00
`define TRIG_COUNT_RST 8'h00
`define TRIG_COUNT_MAX 8'hFF

// ==========================================================
// Timing
`define TRIG_CLK_PERIOD_NS 5
`define TRIG_PULSE_NS 1000
`define TRIG_SETTLE_NS 500
`define TRIG_PULSE_CYCLES ((`TRIG_PULSE_NS + `TRIG_CLK_PERIOD_NS - 1) / `TRIG_CLK_PERIOD_NS)
`define TRIG_SETTLE_CYCLES ((`TRIG_SETTLE_NS + `TRIG_CLK_PERIOD_NS - 1) / `TRIG_CLK_PERIOD_NS)
`define TRIG_TIMER_W 8

`endif

// >>> core/trig_in_sync.v
// Two-stage synchroniser and edge detector for the trigger input lines.
`timescale 1ns/1ps
`include "trig_line_regs.vh"

module trig_in_sync (
  // Clock, reset, enable
  input wire i_clk,
  input wire i_rst,
  input wire i_ce,
  // Raw lines
  input wire [7:0] i_raw,
  // Synchronised levels and edges
  output wire [7:0] o_level,
  output wire [7:0] o_rise,
  output wire [7:0] o_fall
);

  reg [7:0] meta;
  reg [7:0] stable;
  reg [7:0] prev;

  // Only the second stage reads the first one
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta <= `TRIG_IN_RST;
      stable <= `TRIG_IN_RST;
      prev <= `TRIG_IN_RST;
    end else if (i_ce) begin
      meta <= i_raw;
      stable <= meta;
      prev <= stable;
    end
  end

  assign o_level = stable;
  assign o_rise = stable & ~prev;
  assign o_fall = ~stable & prev;

endmodule

// >>> core/trigger_line_controller.v
// Trigger line controller: bus pull-down drive, source select, detection and shorts scan.
`timescale 1ns/1ps
`include "trig_line_regs.vh"

module trigger_line_controller (
  // Clock, reset, enable
  input wire I_CORE_CLK,
  input wire I_RST,
  input wire I_CE,
  // Trigger input pins and bus controller execute trigger
  input wire [5:0] I_TRIG_IN_LINES,
  input wire I_EXT_TRIG_IN,
  input wire I_BUS_EXEC_TRIG_IN,
  // Output line control from software
  input wire [6:0] I_OUT_LEVEL,
  input wire [6:0] I_OUT_PULSE,
  // Source selection and detection
  input wire [2:0] I_SRC_SEL,
  input wire I_SRC_EN,
  input wire I_DETECT_LOW,
  input wire I_FLAG_CLR,
  // Shorts scan control
  input wire I_SCAN_START,
  // Trigger output lines (high switches the pull-down on)
  output wire [5:0] O_TRIG_OUT_LINES,
  output wire O_METER_DONE_OUT,
  // Status
  output reg O_TRIG_FLAG,
  output reg O_TRIG_EVENT,
  output reg [7:0] O_EVENT_COUNT,
  output reg [7:0] O_IN_LEVELS,
  output reg [6:0] O_OUT_BUSY,
  output wire O_SCAN_BUSY,
  output reg O_SCAN_SHORT
);

  // ==========================================================
  // Scan states
  localparam [1:0] SCAN_IDLE = 2'b00;
  localparam [1:0] SCAN_FIRE = 2'b01;
  localparam [1:0] SCAN_WAIT = 2'b10;
  localparam [1:0] SCAN_SETTLE = 2'b11;

  localparam integer PULSE_CYC = `TRIG_PULSE_CYCLES;
  localparam integer SETTLE_CYC = `TRIG_SETTLE_CYCLES;
  localparam [`TRIG_TIMER_W-1:0] PULSE_LOAD = PULSE_CYC[`TRIG_TIMER_W-1:0];
  localparam [`TRIG_TIMER_W-1:0] SETTLE_LOAD = SETTLE_CYC[`TRIG_TIMER_W-1:0];
  localparam [`TRIG_TIMER_W-1:0] TIMER_ONE = {{(`TRIG_TIMER_W-1){1'b0}}, 1'b1};

  reg [1:0] scan_state;
  reg [1:0] next_scan_state;
  reg [2:0] scan_idx;
  reg [2:0] next_scan_idx;
  reg [2:0] scan_sel;
  reg [`TRIG_TIMER_W-1:0] settle_timer;
  reg [`TRIG_TIMER_W-1:0] next_settle_timer;
  reg [6:0] scan_req;
  reg [6:0] out_drive;

  wire [7:0] in_raw;
  wire [7:0] in_level;
  wire [7:0] in_rise;
  wire [7:0] in_fall;
  wire [6:0] pulse_req;
  wire [6:0] pulse_busy;
  wire src_edge;
  wire detect;
  wire [7:0] scan_hot;

  // One-hot decode of a three-bit line index
  function [7:0] onehot8;
    input [2:0] idx;
    begin
      onehot8 = 8'h01 << idx;
    end
  endfunction

  // Whether the scan must skip an output: the paired bus output of the source
  function skip_out;
    input [2:0] idx;
    input [2:0] sel;
    begin
      skip_out = (sel < `TRIG_SEL_BUS_LIMIT) && (idx == sel);
    end
  endfunction

  // ==========================================================
  // Input sensing
  // Meter-complete is never fed back here; only the pins and the bus execute trigger reach detection
  assign in_raw = {I_BUS_EXEC_TRIG_IN, I_EXT_TRIG_IN, I_TRIG_IN_LINES};

  trig_in_sync u_sync (
    .i_clk(I_CORE_CLK),
    .i_rst(I_RST),
    .i_ce(I_CE),
    .i_raw(in_raw),
    .o_level(in_level),
    .o_rise(in_rise),
    .o_fall(in_fall)
  );

  // Bus lines are active low, so falling detection suits them; GET usually wants rising
  assign src_edge = I_DETECT_LOW ? in_fall[I_SRC_SEL] : in_rise[I_SRC_SEL];
  assign detect = I_SRC_EN & src_edge;

  // ==========================================================
  // Output pulse timers, one per output line
  assign pulse_req = I_OUT_PULSE | scan_req;

  genvar g;
  generate
    for (g = 0; g < `TRIG_OUT_COUNT; g = g + 1) begin : g_pulse
      reg [`TRIG_TIMER_W-1:0] timer;
      always @(posedge I_CORE_CLK or posedge I_RST) begin
        if (I_RST) begin
          timer <= {`TRIG_TIMER_W{1'b0}};
        end else if (I_CE) begin
          if (pulse_req[g]) begin
            timer <= PULSE_LOAD;
          end else if (timer != {`TRIG_TIMER_W{1'b0}}) begin
            timer <= timer - TIMER_ONE;
          end
        end
      end
      assign pulse_busy[g] = (timer != {`TRIG_TIMER_W{1'b0}});
    end
  endgenerate

  // ==========================================================
  // Output drive
  always @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      out_drive <= `TRIG_OUT_RST;
      O_OUT_BUSY <= `TRIG_OUT_RST;
    end else if (I_CE) begin
      // Pull-down on while held or pulsing; line otherwise rests high
      out_drive <= I_OUT_LEVEL | pulse_busy | pulse_req;
      O_OUT_BUSY <= pulse_busy;
    end
  end

  assign O_TRIG_OUT_LINES = out_drive[`TRIG_BUS_LINES-1:0];
  assign O_METER_DONE_OUT = out_drive[`TRIG_METER_DONE_BIT];

  // ==========================================================
  // Detection status
  always @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_TRIG_FLAG <= 1'b0;
      O_TRIG_EVENT <= 1'b0;
      O_EVENT_COUNT <= `TRIG_COUNT_RST;
      O_IN_LEVELS <= `TRIG_IN_RST;
      O_SCAN_SHORT <= 1'b0;
    end else if (I_CE) begin
      // A new detection wins over a clear in the same cycle
      O_TRIG_FLAG <= detect | (O_TRIG_FLAG & ~I_FLAG_CLR);
      O_TRIG_EVENT <= detect;
      O_IN_LEVELS <= in_level;
      if (I_FLAG_CLR & ~detect) begin
        O_EVENT_COUNT <= `TRIG_COUNT_RST;
      end else if (detect && O_EVENT_COUNT != `TRIG_COUNT_MAX) begin
        O_EVENT_COUNT <= O_EVENT_COUNT + 8'h01;
      end
      // Any hit while other lines are toggled means a short to the source
      if (scan_state != SCAN_IDLE && detect) begin
        O_SCAN_SHORT <= 1'b1;
      end else if (scan_state == SCAN_IDLE && I_SCAN_START) begin
        O_SCAN_SHORT <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Shorts scan: pulse every other output in turn
  assign scan_hot = onehot8(scan_idx);

  always @* begin
    next_scan_state = scan_state;
    next_scan_idx = scan_idx;
    next_settle_timer = settle_timer;
    scan_req = 7'h00;
    case (scan_state)
      SCAN_IDLE: begin
        if (I_SCAN_START) begin
          next_scan_idx = 3'h0;
          next_scan_state = SCAN_FIRE;
        end
      end
      SCAN_FIRE: begin
        if (skip_out(scan_idx, scan_sel)) begin
          next_scan_state = SCAN_SETTLE;
          next_settle_timer = {`TRIG_TIMER_W{1'b0}};
        end else begin
          scan_req = scan_hot[6:0];
          next_scan_state = SCAN_WAIT;
        end
      end
      SCAN_WAIT: begin
        if (!pulse_busy[scan_idx]) begin
          next_settle_timer = SETTLE_LOAD;
          next_scan_state = SCAN_SETTLE;
        end
      end
      SCAN_SETTLE: begin
        // Settling lets a late edge on the source land inside the scan
        if (settle_timer != {`TRIG_TIMER_W{1'b0}}) begin
          next_settle_timer = settle_timer - TIMER_ONE;
        end else if (scan_idx == `TRIG_SEL_LAST_OUT) begin
          next_scan_state = SCAN_IDLE;
        end else begin
          next_scan_idx = scan_idx + 3'h1;
          next_scan_state = SCAN_FIRE;
        end
      end
      default: begin
        next_scan_state = SCAN_IDLE;
      end
    endcase
  end

  always @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      scan_state <= SCAN_IDLE;
      scan_idx <= 3'h0;
      scan_sel <= 3'h0;
      settle_timer <= {`TRIG_TIMER_W{1'b0}};
    end else if (I_CE) begin
      scan_state <= next_scan_state;
      scan_idx <= next_scan_idx;
      settle_timer <= next_settle_timer;
      if (scan_state == SCAN_IDLE && I_SCAN_START) begin
        scan_sel <= I_SRC_SEL;
      end
    end
  end

  assign O_SCAN_BUSY = (scan_state != SCAN_IDLE);

endmodule

// >>> verif/trig_line_props.sv
// Concurrent checks on the trigger line controller ports.
`timescale 1ns/1ps
module trig_line_props (
  input wire I_CORE_CLK,
  input wire I_RST,
  input wire I_CE,
  input wire [6:0] I_OUT_LEVEL,
  input wire [6:0] I_OUT_PULSE,
  input wire I_SRC_EN,
  input wire I_FLAG_CLR,
  input wire I_SCAN_START,
  input wire [5:0] O_TRIG_OUT_LINES,
  input wire O_METER_DONE_OUT,
  input wire O_TRIG_FLAG,
  input wire O_TRIG_EVENT,
  input wire [7:0] O_EVENT_COUNT,
  input wire O_SCAN_BUSY
);
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RST);
  // ==========================================================
  // Properties
  sequence s_quiet; !I_SRC_EN [*4]; endsequence
  property p_bus_pull; I_CE && I_OUT_PULSE[0] |=> O_TRIG_OUT_LINES[0]; endproperty
  property p_level; I_CE && I_OUT_LEVEL[1] |=> O_TRIG_OUT_LINES[1]; endproperty
  property p_meter; I_CE && I_OUT_PULSE[6] |=> O_METER_DONE_OUT; endproperty
  property p_width; $rose(O_TRIG_OUT_LINES[0]) |-> ##200 O_TRIG_OUT_LINES[0]; endproperty
  property p_ev_flag; O_TRIG_EVENT |-> O_TRIG_FLAG; endproperty
  property p_sticky; O_TRIG_FLAG && !I_FLAG_CLR |=> O_TRIG_FLAG; endproperty
  property p_clear; I_CE && I_FLAG_CLR |=> O_TRIG_FLAG == O_TRIG_EVENT; endproperty
  property p_quiet; s_quiet |=> !O_TRIG_EVENT; endproperty
  property p_count;
    O_TRIG_EVENT && $past(I_CE) && $past(O_EVENT_COUNT) != 8'hFF
      |-> O_EVENT_COUNT == $past(O_EVENT_COUNT) + 8'h01;
  endproperty
  property p_scan; I_CE && I_SCAN_START && !O_SCAN_BUSY |=> O_SCAN_BUSY; endproperty
  a_bus_pull: assert property (p_bus_pull) else $error("pull-down not on");
  a_level: assert property (p_level) else $error("level drive lost");
  a_meter: assert property (p_meter) else $error("meter done not driven");
  a_width: assert property (p_width) else $error("pulse too short");
  a_ev_flag: assert property (p_ev_flag) else $error("event without flag");
  a_sticky: assert property (p_sticky) else $error("flag dropped");
  a_clear: assert property (p_clear) else $error("clear misbehaved");
  a_quiet: assert property (p_quiet) else $error("event while disabled");
  a_count: assert property (p_count) else $error("count not stepped");
  a_scan: assert property (p_scan) else $error("scan did not start");
endmodule
bind trigger_line_controller trig_line_props u_props (
  .I_CORE_CLK(I_CORE_CLK), .I_RST(I_RST), .I_CE(I_CE), .I_OUT_LEVEL(I_OUT_LEVEL),
  .I_OUT_PULSE(I_OUT_PULSE), .I_SRC_EN(I_SRC_EN), .I_FLAG_CLR(I_FLAG_CLR),
  .I_SCAN_START(I_SCAN_START), .O_TRIG_OUT_LINES(O_TRIG_OUT_LINES),
  .O_METER_DONE_OUT(O_METER_DONE_OUT), .O_TRIG_FLAG(O_TRIG_FLAG), .O_TRIG_EVENT(O_TRIG_EVENT),
  .O_EVENT_COUNT(O_EVENT_COUNT), .O_SCAN_BUSY(O_SCAN_BUSY));

// >>> verif/trig_bus_model.sv
// Model of the wiring and other instruments on the trigger lines.
`timescale 1ns/1ps
module trig_bus_model (
  // Drive from the device and from the far side
  input wire [5:0] i_fet,
  input wire i_meter_done,
  input wire [5:0] i_other_pull,
  input wire i_ext_short,
  input wire i_short01,
  // Line levels seen by the device
  output wire [5:0] o_bus,
  output wire o_ext
);
  // Pull-ups hold idle lines high, any pull-down wins
  wire [5:0] pull = i_fet | i_other_pull;
  wire [5:0] sh = i_short01 ? {4'h0, pull[0], pull[1]} : 6'h00;
  assign o_bus = ~(pull | sh);
  // Only a cable outside links meter done to the external input
  assign o_ext = ~(i_ext_short & i_meter_done);
endmodule

// >>> verif/tb_top.sv
// Self-checking bench for the trigger line controller.
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin bad_count++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, a, b); end end
module tb_top;
  logic I_CORE_CLK, I_RST, I_CE, I_BUS_EXEC_TRIG_IN, I_SRC_EN, I_DETECT_LOW;
  logic I_FLAG_CLR, I_SCAN_START, ext_short, short01;
  logic [6:0] I_OUT_LEVEL, I_OUT_PULSE;
  logic [2:0] I_SRC_SEL;
  logic [5:0] other;
  wire [5:0] I_TRIG_IN_LINES, O_TRIG_OUT_LINES;
  wire I_EXT_TRIG_IN, O_METER_DONE_OUT, O_TRIG_FLAG, O_TRIG_EVENT, O_SCAN_BUSY, O_SCAN_SHORT;
  wire [7:0] O_EVENT_COUNT, O_IN_LEVELS;
  wire [6:0] O_OUT_BUSY;
  int bad_count, samples_checked, i, r, s;
  logic [31:0] seed = 32'h0000_6421;
  trigger_line_controller DUT (
    .I_CORE_CLK(I_CORE_CLK), .I_RST(I_RST), .I_CE(I_CE),
    .I_TRIG_IN_LINES(I_TRIG_IN_LINES), .I_EXT_TRIG_IN(I_EXT_TRIG_IN),
    .I_BUS_EXEC_TRIG_IN(I_BUS_EXEC_TRIG_IN), .I_OUT_LEVEL(I_OUT_LEVEL),
    .I_OUT_PULSE(I_OUT_PULSE), .I_SRC_SEL(I_SRC_SEL), .I_SRC_EN(I_SRC_EN),
    .I_DETECT_LOW(I_DETECT_LOW), .I_FLAG_CLR(I_FLAG_CLR), .I_SCAN_START(I_SCAN_START),
    .O_TRIG_OUT_LINES(O_TRIG_OUT_LINES), .O_METER_DONE_OUT(O_METER_DONE_OUT),
    .O_TRIG_FLAG(O_TRIG_FLAG), .O_TRIG_EVENT(O_TRIG_EVENT), .O_EVENT_COUNT(O_EVENT_COUNT),
    .O_IN_LEVELS(O_IN_LEVELS), .O_OUT_BUSY(O_OUT_BUSY), .O_SCAN_BUSY(O_SCAN_BUSY),
    .O_SCAN_SHORT(O_SCAN_SHORT));
  trig_bus_model u_far (.i_fet(O_TRIG_OUT_LINES), .i_meter_done(O_METER_DONE_OUT),
    .i_other_pull(other), .i_ext_short(ext_short), .i_short01(short01),
    .o_bus(I_TRIG_IN_LINES), .o_ext(I_EXT_TRIG_IN));
  initial begin
    I_CORE_CLK = 1'b0;
    forever #2.5 I_CORE_CLK = ~I_CORE_CLK;
  end
  // ==========================================================
  // Helpers
  function int xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return int'(seed[15:0]);
  endfunction
  // A selected source trips only when its own line is pulled
  function logic hit(input int sel, input int pulled);
    return sel == pulled;
  endfunction
  task cyc(input int n);
    repeat (n) @(negedge I_CORE_CLK);
  endtask
  // Select a source, then clear so the switch itself is not counted
  task arm(input int sel, input logic low);
    I_SRC_SEL = sel[2:0];
    I_DETECT_LOW = low;
    cyc(4);
    I_FLAG_CLR = 1;
    cyc(1);
    I_FLAG_CLR = 0;
    cyc(1);
  endtask
  task fire(input int n);
    I_OUT_PULSE = 7'h01 << n;
    cyc(1);
    I_OUT_PULSE = 7'h00;
  endtask
  task scan(input logic exp);
    arm(0, 1);
    I_SCAN_START = 1;
    cyc(1);
    I_SCAN_START = 0;
    for (int n = 0; O_SCAN_BUSY === 1'h1 && n < 5000; n++) cyc(1);
    `CHK(O_SCAN_BUSY, 1'h0)
    `CHK(O_SCAN_SHORT, exp)
  endtask
  task wrap_up;
    $display("checks=%0d errors=%0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  initial begin
    {I_RST, I_CE, I_SRC_EN, I_DETECT_LOW} = 4'hF;
    {I_BUS_EXEC_TRIG_IN, I_FLAG_CLR, I_SCAN_START, ext_short, short01} = 0;
    {I_OUT_LEVEL, I_OUT_PULSE, I_SRC_SEL, other} = 0;
    cyc(5);
    I_RST = 0;
    cyc(1);
    `CHK(O_IN_LEVELS, 8'h7F)
    `CHK({O_TRIG_OUT_LINES, O_METER_DONE_OUT, O_TRIG_FLAG}, 8'h00)
    for (i = 0; i < 6; i++) begin
      arm(i, 1);
      fire(i);
      cyc(3);
      `CHK(I_TRIG_IN_LINES[i], 1'h0)
      cyc(210);
      `CHK(O_TRIG_FLAG, 1'h1)
      `CHK(O_EVENT_COUNT, 8'h01)
    end
    I_OUT_LEVEL = 7'h02;
    cyc(4);
    `CHK(I_TRIG_IN_LINES[1], 1'h0)
    I_OUT_LEVEL = 0;
    // Enable low must freeze a running pulse and its timer
    fire(2);
    cyc(2);
    `CHK(O_OUT_BUSY, 7'h04)
    I_CE = 0;
    cyc(300);
    `CHK(O_TRIG_OUT_LINES, 6'h04)
    I_CE = 1;
    cyc(210);
    `CHK({O_OUT_BUSY, O_TRIG_OUT_LINES}, 13'h0000)
    arm(0, 1);
    I_SRC_EN = 0;
    fire(0);
    cyc(210);
    I_SRC_EN = 1;
    `CHK(O_TRIG_FLAG, 1'h0)
    for (i = 0; i < 2; i++) begin
      ext_short = i[0];
      arm(6, 1);
      fire(6);
      cyc(210);
      `CHK(O_TRIG_FLAG, i[0])
    end
    ext_short = 0;
    arm(7, 0);
    I_BUS_EXEC_TRIG_IN = 1;
    cyc(3);
    I_BUS_EXEC_TRIG_IN = 0;
    cyc(6);
    `CHK(O_TRIG_FLAG, 1'h1)
    // Reset in mid-run returns status and levels to idle
    I_RST = 1;
    cyc(2);
    I_RST = 0;
    cyc(1);
    `CHK(O_IN_LEVELS, 8'h7F)
    `CHK({O_TRIG_FLAG, O_EVENT_COUNT}, 9'h000)
    repeat (6) begin
      r = xs() % 6;
      s = (r + 1 + xs() % 5) % 6;
      for (i = 0; i < 2; i++) begin
        arm(i ? r : s, 1);
        other = 6'h01 << r;
        cyc(8);
        other = 0;
        cyc(8);
        `CHK(O_TRIG_FLAG, hit(i ? r : s, r))
      end
    end
    scan(0);
    short01 = 1;
    scan(1);
    wrap_up;
  end
  initial begin
    #200000;
    bad_count++;
    wrap_up;
  end
endmodule
